// *** verilog/lmes_params.svh ***
// constants for the link master error status block
`ifndef LMES_PARAMS_SVH
`define LMES_PARAMS_SVH

// register byte offsets
`define LMES_OFF_FLAGS    8'h00
`define LMES_OFF_IRQ_STAT 8'h04
`define LMES_OFF_IRQ_MASK 8'h08
`define LMES_OFF_FINAL    8'h0C
`define LMES_OFF_CTRL     8'h10

// flag bit positions
`define LMES_B_LINK_SOME  0
`define LMES_B_LINK_ALL   1
`define LMES_B_RIO        2
`define LMES_B_UNREG      3
`define LMES_B_SPEED      4
`define LMES_B_MULTI      6
`define LMES_B_SWCHG      8
`define LMES_B_HWERR      15

// valid flag bits; bits 5, 7 and 9..14 always read zero
`define LMES_FLAG_MASK    16'h815F
`define LMES_FLAGS_RST    16'h0000
`define LMES_MASK_RST     16'h0000
`define LMES_FINAL_RST    7'h40

// multi-station permitted range, highest valid speed setting
`define LMES_MULTI_LO     7'h31
`define LMES_MULTI_HI     7'h40
`define LMES_SPEED_MAX    3'h4

// axi responses
`define LMES_RESP_OKAY    2'h0
`define LMES_RESP_SLVERR  2'h2

`endif

// *** verilog/lmes_pkg.sv ***
// types for the link master error status block
package lmes_pkg;
  // axi lite slave phases
  typedef enum logic [1:0] {
    LMES_IDLE = 2'h0,
    LMES_RESP = 2'h1
  } lmes_bus_t;
endpackage

// *** verilog/lmes_sync.sv ***
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module lmes_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         arst_n,
  // async level in, synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg; // first stage, read only by second
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  // next values: plain shift
  always_comb begin
    meta_next = d;
    q_next    = meta_reg;
  end

  // registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end
endmodule // lmes_sync

// *** verilog/lmes_top.sv ***
// error status word of a built-in field network master, axi lite slave
//
// What this block does
// - bit 0 when any link error word set
// - bit 1 when link failed all stations
// - bit 2 when any remote error set
// - bit 3 on unregistered station connected
// - bit 3 self clears at or below final only
// - bit 4 on bad speed, power reset
// - bit 6 multi-station outside 49..64
// - bit 6 multi-station in four-point mode
// - bit 8 when switches differ from power-on
// - bit 8 clears when switches restored
// - bit 15 on loop-back test failure
// - bit 15 clears only on power reset once set
// - keep final station number from configuration
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "lmes_params.svh"
module lmes_top import lmes_pkg::*; (
  // clock and reset (arst_n models power reset)
  input  wire logic        clock,
  input  wire logic        arst_n,
  // axi lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // error sources from the link engine (async pins)
  input  wire logic [63:0] link_err_map,
  input  wire logic [63:0] rio_err_map,
  input  wire logic        link_all_fail,
  input  wire logic        unreg_seen,
  input  wire logic [6:0]  unreg_station,
  input  wire logic        multi_seen,
  input  wire logic [6:0]  multi_station,
  input  wire logic        loopback_fail,
  // operation switches and speed selector
  input  wire logic [7:0]  op_switches,
  input  wire logic [2:0]  speed_switch,
  input  wire logic        four_point_mode,
  // interrupt
  output logic             irq
);
  // synchronised pin levels
  localparam int SW = 64 + 64 + 1 + 1 + 7 + 1 + 7 + 1 + 8 + 3 + 1;
  logic [SW-1:0] pins_async;
  logic [SW-1:0] pins_s;
  logic [63:0]   link_s, rio_s;
  logic          all_s, unreg_s, multi_s, loop_s, four_s;
  logic [6:0]    unreg_st_s, multi_st_s;
  logic [7:0]    sw_s;
  logic [2:0]    speed_s;

  assign pins_async = {link_err_map, rio_err_map, link_all_fail,
                       unreg_seen, unreg_station, multi_seen,
                       multi_station, loopback_fail, op_switches,
                       speed_switch, four_point_mode};

  // every pin passes two flops before use
  // trade-off: live flag bits lag the pins by two cycles, latched ones by three, in return
  // every field is free of metastability when it is read
  lmes_sync #(.W(SW)) u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .d      (pins_async),
    .q      (pins_s)
  );

  // unpack in the same order as packed above
  assign {link_s, rio_s, all_s, unreg_s, unreg_st_s, multi_s,
          multi_st_s, loop_s, sw_s, speed_s, four_s} = pins_s;

  // state
  logic [15:0] sticky_reg, sticky_next;   // power-reset-only flags
  logic [15:0] flags;                     // visible error word
  logic [7:0]  sw_base_reg, sw_base_next; // switches at power on
  logic        armed_reg, armed_next;     // power-on capture done
  logic [1:0]  fill_reg, fill_next;       // sync stages filled
  logic [6:0]  final_reg, final_next;     // final station number
  logic [15:0] istat_reg, istat_next;     // sticky interrupt status
  logic [15:0] imask_reg, imask_next;     // interrupt mask
  logic [15:0] flags_prev_reg;            // for rising edge events
  logic [15:0] rise;

  // bus state
  lmes_bus_t   wst_reg, wst_next, rst_reg, rst_next;
  logic        aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [7:0]  awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        wr_fire;

  // visible flags: live conditions or latched ones
  always_comb begin
    flags = `LMES_FLAGS_RST;
    flags[`LMES_B_LINK_SOME] = |link_s;
    flags[`LMES_B_LINK_ALL]  = all_s;
    flags[`LMES_B_RIO]       = |rio_s;
    // at or below final station: follows the cause directly
    flags[`LMES_B_UNREG] = (unreg_s && unreg_st_s <= final_reg) ||
                           sticky_reg[`LMES_B_UNREG];
    flags[`LMES_B_SPEED] = sticky_reg[`LMES_B_SPEED];
    flags[`LMES_B_MULTI] = sticky_reg[`LMES_B_MULTI];
    flags[`LMES_B_SWCHG] = armed_reg && (sw_s != sw_base_reg);
    flags[`LMES_B_HWERR] = sticky_reg[`LMES_B_HWERR];
    flags = flags & `LMES_FLAG_MASK;
  end

  // latched flags: set only; power reset is the one clear
  // a stray glitch on a pin sticks until power reset, so the
  // sources must be clean whenever they are sampled
  always_comb begin
    sticky_next = sticky_reg;
    if (unreg_s && unreg_st_s > final_reg)
      sticky_next[`LMES_B_UNREG] = 1'b1;
    if (armed_reg && speed_s > `LMES_SPEED_MAX)
      sticky_next[`LMES_B_SPEED] = 1'b1;
    if (multi_s && (multi_st_s < `LMES_MULTI_LO ||
                    multi_st_s > `LMES_MULTI_HI))
      sticky_next[`LMES_B_MULTI] = 1'b1;
    if (multi_s && four_s)
      sticky_next[`LMES_B_MULTI] = 1'b1;
    if (loop_s)
      sticky_next[`LMES_B_HWERR] = 1'b1;
    // power-on capture waits until both sync stages hold the pins;
    // they clear on reset, so an early capture would record zeros
    // and raise the switch-change flag for no reason
    fill_next    = {fill_reg[0], 1'b1};
    armed_next   = fill_reg[1];
    sw_base_next = armed_reg ? sw_base_reg : sw_s;
  end

  // interrupt status: rising flags set, write one clears; set wins
  // a flag that stays high raises its status bit only once
  // a write fires one cycle after both halves are held, so the
  // response never overlaps the register update
  assign rise = flags & ~flags_prev_reg;
  assign wr_fire = aw_got_reg && w_got_reg && wst_reg == LMES_IDLE;
  always_comb begin
    istat_next = istat_reg;
    imask_next = imask_reg;
    final_next = final_reg;
    if (wr_fire && wstrb_reg[0] && wstrb_reg[1]) begin
      case (awaddr_reg)
        `LMES_OFF_IRQ_STAT: istat_next = istat_reg & ~wdata_reg[15:0];
        `LMES_OFF_IRQ_MASK: imask_next = wdata_reg[15:0] & `LMES_FLAG_MASK;
        default: ;
      endcase
    end
    // final station from stored configuration, software loaded
    if (wr_fire && wstrb_reg[0] && awaddr_reg == `LMES_OFF_FINAL)
      final_next = wdata_reg[6:0];
    istat_next = istat_next | rise;
  end

  // write channel: take aw and w in either order, then respond
  always_comb begin
    wst_next    = wst_reg;
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next  = wdata_reg;
    wstrb_next  = wstrb_reg;
    bresp_next  = bresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    case (wst_reg)
      LMES_IDLE: begin
        if (wr_fire) begin
          aw_got_next = 1'b0;
          w_got_next  = 1'b0;
          wst_next    = LMES_RESP;
          case (awaddr_reg)
            `LMES_OFF_IRQ_STAT, `LMES_OFF_IRQ_MASK,
            `LMES_OFF_FINAL: bresp_next = `LMES_RESP_OKAY;
            // flag word is read only
            default: bresp_next = `LMES_RESP_SLVERR;
          endcase
        end
      end
      LMES_RESP: begin
        if (s_axi_bready)
          wst_next = LMES_IDLE;
      end
      default: wst_next = LMES_IDLE;
    endcase
  end

  // read channel: one cycle decode, hold until rready
  always_comb begin
    rst_next   = rst_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    case (rst_reg)
      LMES_IDLE: begin
        // flags are sampled at the address edge; a later change
        // shows up on the next read
        if (s_axi_arvalid) begin
          rst_next   = LMES_RESP;
          rresp_next = `LMES_RESP_OKAY;
          case (s_axi_araddr)
            `LMES_OFF_FLAGS:    rdata_next = {16'h0000, flags};
            `LMES_OFF_IRQ_STAT: rdata_next = {16'h0000, istat_reg};
            `LMES_OFF_IRQ_MASK: rdata_next = {16'h0000, imask_reg};
            `LMES_OFF_FINAL:    rdata_next = {25'h0000000, final_reg};
            default: begin
              rdata_next = 32'h00000000;
              rresp_next = `LMES_RESP_SLVERR;
            end
          endcase
        end
      end
      LMES_RESP: begin
        if (s_axi_rready)
          rst_next = LMES_IDLE;
      end
      default: rst_next = LMES_IDLE;
    endcase
  end

  // handshake outputs
  // ready and valid come from state; payloads come from registers
  assign s_axi_awready = !aw_got_reg && wst_reg == LMES_IDLE;
  assign s_axi_wready  = !w_got_reg && wst_reg == LMES_IDLE;
  assign s_axi_bvalid  = wst_reg == LMES_RESP;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = rst_reg == LMES_IDLE;
  assign s_axi_rvalid  = rst_reg == LMES_RESP;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // registers
  // everything but final_reg (loaded with 7'h40) clears on power reset; that reset is the only way
  // the latched flags and the switch baseline are renewed
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sticky_reg     <= `LMES_FLAGS_RST;
      sw_base_reg    <= 8'h00;
      armed_reg      <= 1'b0;
      fill_reg       <= 2'h0;
      final_reg      <= `LMES_FINAL_RST;
      istat_reg      <= `LMES_FLAGS_RST;
      imask_reg      <= `LMES_MASK_RST;
      flags_prev_reg <= `LMES_FLAGS_RST;
      irq            <= 1'b0;
      wst_reg        <= LMES_IDLE;
      rst_reg        <= LMES_IDLE;
      aw_got_reg     <= 1'b0;
      w_got_reg      <= 1'b0;
      awaddr_reg     <= 8'h00;
      wdata_reg      <= 32'h00000000;
      wstrb_reg      <= 4'h0;
      bresp_reg      <= `LMES_RESP_OKAY;
      rresp_reg      <= `LMES_RESP_OKAY;
      rdata_reg      <= 32'h00000000;
    end else begin
      sticky_reg     <= sticky_next;
      sw_base_reg    <= sw_base_next;
      armed_reg      <= armed_next;
      fill_reg       <= fill_next;
      final_reg      <= final_next;
      istat_reg      <= istat_next;
      imask_reg      <= imask_next;
      flags_prev_reg <= flags;
      irq            <= |(istat_next & imask_next);
      wst_reg        <= wst_next;
      rst_reg        <= rst_next;
      aw_got_reg     <= aw_got_next;
      w_got_reg      <= w_got_next;
      awaddr_reg     <= awaddr_next;
      wdata_reg      <= wdata_next;
      wstrb_reg      <= wstrb_next;
      bresp_reg      <= bresp_next;
      rresp_reg      <= rresp_next;
      rdata_reg      <= rdata_next;
    end
  end
endmodule // lmes_top

// *** sim/lmes_top_monitor.sv ***
// checker of the error flag word seen through the read channel
`timescale 1ns/1ps
module lmes_top_monitor (
  // clock and reset
  input wire logic        clock,
  input wire logic        arst_n,
  // read channel
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  // error sources and switches
  input wire logic [63:0] link_err_map,
  input wire logic [63:0] rio_err_map,
  input wire logic        link_all_fail,
  input wire logic        unreg_seen,
  input wire logic [6:0]  unreg_station,
  input wire logic        multi_seen,
  input wire logic [6:0]  multi_station,
  input wire logic        loopback_fail,
  input wire logic [7:0]  op_switches,
  input wire logic [2:0]  speed_switch,
  input wire logic        four_point_mode
);
  logic [7:0]   raddr_reg;  // address of the read in flight
  logic [15:0]  sticky_reg; // latched flags already read as set
  logic [2:0]   quiet_reg;  // cycles since any source moved
  logic [7:0]   base_reg;   // switch positions after power on
  logic         armed_reg;  // baseline taken
  logic [157:0] src_reg;    // sources one cycle ago
  logic [157:0] src;        // all sources side by side
  logic         ok;         // settled read of the flag word
  assign src = {link_err_map, rio_err_map, link_all_fail, unreg_seen,
    unreg_station, multi_seen, multi_station, loopback_fail,
    op_switches, speed_switch, four_point_mode};
  // sync chain is two deep, so the per-bit flag checks judge settled reads only
  assign ok = s_axi_rvalid && raddr_reg == 8'h00 && quiet_reg == 3'h7;
  // helper state, cleared by power reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      raddr_reg <= 8'h00;
      sticky_reg <= 16'h0000;
      quiet_reg <= 3'h0;
      base_reg <= 8'h00;
      armed_reg <= 1'b0;
      src_reg <= '0;
    end else begin
      src_reg <= src;
      quiet_reg <= (src != src_reg) ? 3'h0 :
        quiet_reg + {2'h0, quiet_reg != 3'h7};
      armed_reg <= 1'b1;
      if (!armed_reg) base_reg <= op_switches;
      if (s_axi_arvalid && s_axi_arready) raddr_reg <= s_axi_araddr;
      if (s_axi_rvalid && raddr_reg == 8'h00)
        sticky_reg <= sticky_reg | (s_axi_rdata[15:0] & 16'h8050);
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_rsvd_zero: assert property (s_axi_rvalid && raddr_reg == 8'h00 |->
    (s_axi_rdata & ~32'h0000_815F) == 32'h0) else $error("reserved bit set");
  a_latch_hold: assert property (s_axi_rvalid && raddr_reg == 8'h00 |->
    (s_axi_rdata[15:0] & sticky_reg) == sticky_reg) else $error("latch lost");
  a_link_some: assert property (ok |->
    s_axi_rdata[0] == |link_err_map) else $error("bit 0 wrong");
  a_link_all: assert property (ok |->
    s_axi_rdata[1] == link_all_fail) else $error("bit 1 wrong");
  a_rio_any: assert property (ok |->
    s_axi_rdata[2] == |rio_err_map) else $error("bit 2 wrong");
  a_unreg_set: assert property (ok && unreg_seen |->
    s_axi_rdata[3]) else $error("bit 3 missing");
  a_multi_set: assert property (ok && multi_seen && (four_point_mode ||
    multi_station < 7'h31 || multi_station > 7'h40) |-> s_axi_rdata[6])
    else $error("bit 6 missing");
  a_switch_moved: assert property (ok && armed_reg |->
    s_axi_rdata[8] == (op_switches != base_reg)) else $error("bit 8 wrong");
  a_loop_fail: assert property (ok && loopback_fail |->
    s_axi_rdata[15]) else $error("bit 15 missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered");
endmodule // lmes_top_monitor

bind lmes_top lmes_top_monitor i_lmes_top_monitor (.clock, .arst_n,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .link_err_map, .rio_err_map, .link_all_fail, .unreg_seen,
  .unreg_station, .multi_seen, .multi_station, .loopback_fail,
  .op_switches, .speed_switch, .four_point_mode);

// *** sim/lmes_stations.sv ***
// behavioural model of the remote stations on the field network
`timescale 1ns/1ps
module lmes_stations (
  // clock and event command from the bench
  input wire logic       clock,
  input wire logic       upd,
  input wire logic [2:0] kind,
  input wire logic [6:0] st,
  input wire logic       on,
  // error pins toward the master
  output logic [63:0]    link_err_map,
  output logic [63:0]    rio_err_map,
  output logic           link_all_fail,
  output logic           unreg_seen,
  output logic [6:0]     unreg_station,
  output logic           multi_seen,
  output logic [6:0]     multi_station,
  output logic           loopback_fail
);
  logic [5:0] idx; // station 1..64 as a map index
  assign idx = 6'(st - 7'h01);
  // all stations healthy at start, then one event per strobe;
  // one process drives every pin so each has a single driver
  initial begin
    {link_err_map, rio_err_map, link_all_fail, unreg_seen} = '0;
    {unreg_station, multi_seen, multi_station, loopback_fail} = '0;
    forever begin
      @(posedge clock);
      // a released station number is garbage, never the last value
      if (upd) begin
        case (kind)
          3'h0: link_err_map[idx] <= on;
          3'h1: link_all_fail <= on;
          3'h2: rio_err_map[idx] <= on;
          3'h3: {unreg_seen, unreg_station} <= {on, on ? st : ~st};
          3'h4: {multi_seen, multi_station} <= {on, on ? st : ~st};
          default: loopback_fail <= on;
        endcase
      end
    end
  end
endmodule // lmes_stations

// *** sim/tb_lmes_top.sv ***
// self-checking bench for the error status block
`timescale 1ns/1ps
`include "lmes_params.svh"
module tb_lmes_top;
  logic clock, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, upd, on, four_point_mode;
  logic [7:0] s_axi_awaddr, s_axi_araddr, op_switches;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, link_all_fail, unreg_seen, multi_seen;
  logic loopback_fail, aw_ok, w_ok;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] kind, speed_switch;
  logic [6:0] st, s, unreg_station, multi_station;
  logic [63:0] link_err_map, rio_err_map;
  logic [15:0] ef; // expected flag word
  logic [31:0] m_cur; // mask of the read being compared
  logic [31:0] exp_d[$], exp_m[$];
  logic [1:0] exp_r[$], exp_b[$];
  int fail_count, compares, n;
  lmes_top i_lmes_top (.clock, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_err_map,
    .rio_err_map, .link_all_fail, .unreg_seen, .unreg_station, .multi_seen,
    .multi_station, .loopback_fail, .op_switches, .speed_switch,
    .four_point_mode, .irq);
  lmes_stations i_lmes_stations (.clock, .upd, .kind, .st, .on,
    .link_err_map, .rio_err_map, .link_all_fail, .unreg_seen,
    .unreg_station, .multi_seen, .multi_station, .loopback_fail);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task stop_test;
    if (exp_d.size() != 0 || exp_b.size() != 0) fail_count++;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // answers are compared where they settle, mid-cycle
  always @(negedge clock) begin
    if (s_axi_rvalid && s_axi_rready) begin
      m_cur = exp_m.pop_front();
      chk(s_axi_rdata & m_cur, exp_d.pop_front() & m_cur);
      chk({30'h0, s_axi_rresp}, {30'h0, exp_r.pop_front()});
    end
    if (s_axi_bvalid && s_axi_bready)
      chk({30'h0, s_axi_bresp}, {30'h0, exp_b.pop_front()});
  end
  // read: hold request until its ready edge, then wait for data
  task rd(input logic [7:0] a, input logic [31:0] d, m, input logic [1:0] r);
    exp_d.push_back(d);
    exp_m.push_back(m);
    exp_r.push_back(r);
    @(posedge clock);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    n = 0;
    do begin @(negedge clock); n++; end while (!s_axi_arready);
    @(posedge clock);
    s_axi_arvalid <= 1'b0;
    do begin @(negedge clock); n++; end while (!s_axi_rvalid);
    @(posedge clock);
    s_axi_rready <= 1'b0;
  endtask
  // write: each channel released on its own handshake edge
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    n = 0;
    do begin
      @(negedge clock);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok = s_axi_wvalid && s_axi_wready;
      n++;
      @(posedge clock);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !aw_ok || s_axi_wvalid && !w_ok);
    do begin @(negedge clock); n++; end while (!s_axi_bvalid);
    @(posedge clock);
    s_axi_bready <= 1'b0;
  endtask
  // station event, then let the input synchronisers settle
  task ev(input logic [2:0] k, input logic [6:0] sn, input logic o);
    @(posedge clock);
    {kind, st, on, upd} <= {k, sn, o, 1'b1};
    @(posedge clock);
    upd <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  task fl;
    rd(`LMES_OFF_FLAGS, {16'h0, ef}, 32'hFFFF_FFFF, `LMES_RESP_OKAY);
  endtask
  task pwr;
    arst_n <= 1'b0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (8) @(posedge clock);
    ef = 16'h0000;
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_rready, upd, on, four_point_mode, kind, st} = '0;
    arst_n = 1'b0;
    {op_switches, speed_switch, fail_count, compares} = {8'h5A, 3'h2, 64'h0};
    n = $urandom(48);
    pwr();
    fl();
    rd(`LMES_OFF_FINAL, 32'h40, 32'h7F, `LMES_RESP_OKAY);
    wr(`LMES_OFF_FINAL, 32'h0A, `LMES_RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      s = (k == 3) ? 7'h05 : 7'($urandom % 64 + 1);
      ev(3'(k), s, 1'b1);
      ef = 16'h1 << k;
      fl();
      ev(3'(k), s, 1'b0);
      ef = 16'h0;
      fl();
    end
    ev(3'h3, 7'd20, 1'b1);
    ef = 16'h0008;
    fl();
    ev(3'h3, 7'd20, 1'b0);
    fl();
    ev(3'h4, 7'd30, 1'b1);
    ef |= 16'h0040;
    fl();
    ev(3'h4, 7'd30, 1'b0);
    fl();
    speed_switch <= 3'h7;
    ev(3'h5, 7'h00, 1'b1);
    ef |= 16'h8010;
    fl();
    speed_switch <= 3'h2;
    ev(3'h5, 7'h00, 1'b0);
    fl();
    op_switches <= 8'hA5;
    ev(3'h0, 7'h01, 1'b0);
    ef |= 16'h0100;
    fl();
    op_switches <= 8'h5A;
    ev(3'h0, 7'h01, 1'b0);
    ef &= ~16'h0100;
    fl();
    rd(`LMES_OFF_IRQ_STAT, 32'h815F, 32'hFFFF, `LMES_RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wr(`LMES_OFF_IRQ_MASK, 32'hFFFF, `LMES_RESP_OKAY);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    wr(`LMES_OFF_IRQ_STAT, 32'h815F, `LMES_RESP_OKAY);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    rd(8'h14, 32'h0, 32'hFFFF_FFFF, `LMES_RESP_SLVERR);
    wr(`LMES_OFF_FLAGS, 32'hFFFF, `LMES_RESP_SLVERR);
    fl();
    pwr();
    fl();
    ev(3'h4, 7'd49, 1'b1);
    fl();
    four_point_mode <= 1'b1;
    ev(3'h4, 7'd49, 1'b1);
    ef = 16'h0040;
    fl();
    stop_test();
  end
  // cut a hang short; the run needs about 300 cycles
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
endmodule // tb_lmes_top
